//--- src/rrc_pkg.sv
/*
 * Package of the remote-terminal control block: register offsets, field
 * positions, reset values and timing counts.
 * Assumes a 10 MHz system clock and a 32-bit classic Wishbone slave port.
 */
package rrc_pkg;

	// ************************************************************
	// Register byte offsets
	// ************************************************************
	localparam logic [7:0] CTRL_OFFSET     = 8'h00;
	localparam logic [7:0] STATE_OFFSET    = 8'h04;
	localparam logic [7:0] IRQ_STAT_OFFSET = 8'h08;
	localparam logic [7:0] IRQ_MASK_OFFSET = 8'h0c;
	localparam logic [7:0] JUDGE_OFFSET    = 8'h10;
	localparam logic [7:0] FAULT_OFFSET    = 8'h14;

	// ************************************************************
	// Control register fields
	// ************************************************************
	localparam int CTRL_MODE_BIT   = 0;  // 0 real-time, 1 memory
	localparam int CTRL_EXT_BIT    = 1;  // External pacing selected
	localparam int CTRL_SCALE_BIT  = 2;  // 1 = four pulses per line
	localparam int CTRL_REPEAT_BIT = 3;  // Repeating acquisition
	localparam int CTRL_WIDTH      = 4;
	localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 4'h0;

	// ************************************************************
	// State register fields
	// ************************************************************
	localparam int ST_REC_BIT    = 0;
	localparam int ST_FEED_BIT   = 1;
	localparam int ST_HALT_BIT   = 2;
	localparam int ST_ERROR_BIT  = 3;
	localparam int ST_ACQ_BIT    = 4;

	// ************************************************************
	// Interrupt status fields (sticky, write one to clear)
	// ************************************************************
	localparam int IRQ_REC_START = 0;
	localparam int IRQ_REC_STOP  = 1;
	localparam int IRQ_MARK      = 2;
	localparam int IRQ_LINE      = 3;
	localparam int IRQ_SAMPLE    = 4;
	localparam int IRQ_HALT      = 5;
	localparam int IRQ_ERROR     = 6;
	localparam int IRQ_WIDTH     = 7;
	localparam logic [IRQ_WIDTH-1:0] IRQ_RESET = 7'h00;

	// ************************************************************
	// Judgment register fields
	// ************************************************************
	localparam int JUDGE_WIDTH      = 2;  // Result outputs
	localparam int JUDGE_DONE_BIT   = 8;  // Write: one judgment completed
	localparam int JUDGE_BLOCK_BIT  = 9;  // Write: next memory block begins
	localparam logic [JUDGE_WIDTH-1:0] JUDGE_RESET = 2'h0;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_HZ          = 10_000_000;
	localparam int MARK_NS         = 1000;  // Mark strobe width
	localparam int MARK_CYCLES     = (MARK_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam logic [1:0] SCALE_FINE_COUNT = 2'h3;  // Four pulses per line

endpackage

//--- src/rrc_remote_io.sv
/*
 * Remote-terminal control logic of a chart recorder: active-low remote
 * start, feed, mark and protect inputs, an external pacing pulse input,
 * printing-block error output and judgment result outputs.
 * Assumes all remote inputs are asynchronous pins and that software sets
 * mode and pacing over a classic Wishbone slave on the same clock.
 * Assumes the recorder engine reads the control outputs on this clock.
 */
`timescale 1ns/100ps

module rrc_remote_io (
	// Clock and reset
	input  wire logic        I_REF_CLK,
	input  wire logic        I_RESET_N,
	// Remote terminal inputs, active low levels; print sync and pacing pulse active high
	input  wire logic        I_REC_N,
	input  wire logic        I_FEED_N,
	input  wire logic        I_MARK_N,
	input  wire logic        I_PROTECT_N,
	input  wire logic        I_PRINT_SYNC,
	input  wire logic        I_EXTERNAL_PULSE_IN,
	// Printing block fault sources
	input  wire logic        I_PAPER_OUT,
	input  wire logic        I_HEAD_TEMP_FAULT,
	// Remote terminal outputs
	output logic             O_ERROR_N,
	output logic [1:0]       O_JUDGE,
	// Recorder engine controls
	output logic             O_RECORDING,
	output logic             O_FEEDING,
	output logic             O_MARK_PRINT,
	output logic             O_LINE_ADVANCE,
	output logic             O_FILE_SAMPLE,
	output logic             O_MEM_SAMPLE,
	output logic             O_HALT_REQ,
	// Wishbone slave
	input  wire logic        I_WB_CYC,
	input  wire logic        I_WB_STB,
	input  wire logic        I_WB_WE,
	input  wire logic [7:0]  I_WB_ADR,
	input  wire logic [3:0]  I_WB_SEL,
	input  wire logic [31:0] I_WB_DAT,
	output logic [31:0]      O_WB_DAT,
	output logic             O_WB_ACK,
	// Interrupt
	output logic             O_IRQ
);

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		logic [5:0]                       sync1;
		logic [5:0]                       sync2;
		logic [5:0]                       prev;
		logic [1:0]                       fault_s1;
		logic [1:0]                       fault_s2;
		logic                             rec;
		logic                             feed;
		logic                             halt;
		logic                             err_n;
		logic                             acq;
		logic [1:0]                       judge;
		logic [1:0]                       pulse_div;
		logic [1:0]                       sample_div;
		logic                             mark;
		logic                             line;
		logic                             file_smp;
		logic                             mem_smp;
		logic [7:0]                       mark_cnt;
		logic [rrc_pkg::CTRL_WIDTH-1:0]   ctrl;
		logic [rrc_pkg::IRQ_WIDTH-1:0]    irq_stat;
		logic [rrc_pkg::IRQ_WIDTH-1:0]    irq_mask;
		logic                             irq;
		logic [31:0]                      rdata;
		logic                             ack;
	} rrc_state_t;

	rrc_state_t state;
	rrc_state_t next_state;

	// Remote-pin synchronisers reset to ones so idle-high pins give no edge at release
	localparam rrc_state_t STATE_RESET = '{
		sync1:      6'h3f,
		sync2:      6'h3f,
		prev:       6'h3f,
		fault_s1:   2'h0,
		fault_s2:   2'h0,
		rec:        1'b0,
		feed:       1'b0,
		halt:       1'b0,
		err_n:      1'b1,
		acq:        1'b0,
		judge:      rrc_pkg::JUDGE_RESET,
		pulse_div:  2'h0,
		sample_div: 2'h0,
		mark:       1'b0,
		line:       1'b0,
		file_smp:   1'b0,
		mem_smp:    1'b0,
		mark_cnt:   8'h00,
		ctrl:       rrc_pkg::CTRL_RESET,
		irq_stat:   rrc_pkg::IRQ_RESET,
		irq_mask:   rrc_pkg::IRQ_RESET,
		irq:        1'b0,
		rdata:      32'h0000_0000,
		ack:        1'b0
	};

	// ************************************************************
	// Input order in sync vectors
	// ************************************************************
	localparam int IN_REC   = 0;
	localparam int IN_FEED  = 1;
	localparam int IN_MARK  = 2;
	localparam int IN_PROT  = 3;
	localparam int IN_PSYNC = 4;
	localparam int IN_EXT   = 5;

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		logic [5:0]                    rise;
		logic [5:0]                    fall;
		logic [rrc_pkg::IRQ_WIDTH-1:0] events;
		logic                          real_time;
		logic                          ext_pace;
		logic                          fine;
		logic                          wr;
		logic                          rd;
		logic                          fault;
		logic                          line_pulse;
		rise       = 6'h00;
		fall       = 6'h00;
		events     = '0;
		real_time  = 1'b0;
		ext_pace   = 1'b0;
		fine       = 1'b0;
		wr         = 1'b0;
		rd         = 1'b0;
		fault      = 1'b0;
		line_pulse = 1'b0;
		next_state = state;

		// ************************************************************
		// Two-stage synchronisers for all remote pins
		// ************************************************************
		next_state.sync1[IN_REC]   = I_REC_N;
		next_state.sync1[IN_FEED]  = I_FEED_N;
		next_state.sync1[IN_MARK]  = I_MARK_N;
		next_state.sync1[IN_PROT]  = I_PROTECT_N;
		next_state.sync1[IN_PSYNC] = I_PRINT_SYNC;
		next_state.sync1[IN_EXT]   = I_EXTERNAL_PULSE_IN;
		next_state.sync2    = state.sync1;
		next_state.prev     = state.sync2;
		next_state.fault_s1 = {I_HEAD_TEMP_FAULT, I_PAPER_OUT};
		next_state.fault_s2 = state.fault_s1;
		rise = state.sync2 & ~state.prev;
		fall = ~state.sync2 & state.prev;

		real_time = ~state.ctrl[rrc_pkg::CTRL_MODE_BIT];
		ext_pace  = state.ctrl[rrc_pkg::CTRL_EXT_BIT];
		fine      = state.ctrl[rrc_pkg::CTRL_SCALE_BIT];

		// ************************************************************
		// Recording and feed follow the remote levels after an edge
		// ************************************************************
		if (fall[IN_REC]) begin
			next_state.rec = 1'b1;
			next_state.acq = 1'b1;
			next_state.judge = rrc_pkg::JUDGE_RESET;
			events[rrc_pkg::IRQ_REC_START] = 1'b1;
		end else if (rise[IN_REC]) begin
			next_state.rec = 1'b0;
			next_state.acq = 1'b0;
			events[rrc_pkg::IRQ_REC_STOP] = 1'b1;
		end
		if (fall[IN_FEED]) begin
			next_state.feed = 1'b1;
		end else if (rise[IN_FEED]) begin
			next_state.feed = 1'b0;
		end

		// ************************************************************
		// Mark strobe, real-time recording only
		// ************************************************************
		// A new rise reloads the counter rather than adding a second strobe
		next_state.mark = 1'b0;
		if (state.mark_cnt != 8'h00) begin
			next_state.mark_cnt = state.mark_cnt - 8'h01;
			next_state.mark = 1'b1;
		end
		if (rise[IN_MARK] && real_time && state.rec) begin
			next_state.mark_cnt = 8'(rrc_pkg::MARK_CYCLES - 1);
			next_state.mark = 1'b1;
			events[rrc_pkg::IRQ_MARK] = 1'b1;
		end

		// ************************************************************
		// Protect request latches a halt until reset
		// ************************************************************
		// A bouncing protect pin must not abort a shutdown in progress
		if (fall[IN_PROT] && !state.halt) begin
			next_state.halt = 1'b1;
			events[rrc_pkg::IRQ_HALT] = 1'b1;
		end

		// ************************************************************
		// Printing block error, independent of recording
		// ************************************************************
		// Level follows the synchronised faults; the interrupt marks onset
		fault = |state.fault_s2;
		next_state.err_n = ~fault;
		if (fault && state.err_n) begin
			events[rrc_pkg::IRQ_ERROR] = 1'b1;
		end

		// ************************************************************
		// External pacing in real-time mode; scale only here
		// ************************************************************
		// Print sync paces lines, the pulse input paces filing: two dividers
		next_state.line     = 1'b0;
		next_state.file_smp = 1'b0;
		next_state.mem_smp  = 1'b0;
		if (real_time && ext_pace && state.rec) begin
			if (rise[IN_PSYNC]) begin
				if (!fine || state.pulse_div == rrc_pkg::SCALE_FINE_COUNT) begin
					next_state.pulse_div = 2'h0;
					line_pulse = 1'b1;
				end else begin
					next_state.pulse_div = state.pulse_div + 2'h1;
				end
			end
			if (rise[IN_EXT]) begin
				if (!fine || state.sample_div == rrc_pkg::SCALE_FINE_COUNT) begin
					next_state.sample_div = 2'h0;
					next_state.file_smp = 1'b1;
					events[rrc_pkg::IRQ_SAMPLE] = 1'b1;
				end else begin
					next_state.sample_div = state.sample_div + 2'h1;
				end
			end
		end else begin
			next_state.pulse_div  = 2'h0;
			next_state.sample_div = 2'h0;
		end
		next_state.line = line_pulse;
		if (line_pulse) begin
			events[rrc_pkg::IRQ_LINE] = 1'b1;
		end

		// ************************************************************
		// Memory mode: one sample per pulse, no scale
		// ************************************************************
		if (!real_time && ext_pace && state.rec && rise[IN_EXT]) begin
			next_state.mem_smp = 1'b1;
			events[rrc_pkg::IRQ_SAMPLE] = 1'b1;
		end

		// ************************************************************
		// Wishbone single-cycle slave, ack one cycle after request
		// ************************************************************
		// Read data is latched when the request is taken; a write lands
		// at the edge where the master samples ack, request still held
		next_state.ack = 1'b0;
		if (I_WB_CYC && I_WB_STB && !state.ack) begin
			next_state.ack = 1'b1;
			rd = ~I_WB_WE;
		end
		if (I_WB_CYC && I_WB_STB && state.ack) begin
			wr = I_WB_WE;
		end
		if (rd) begin
			unique case (I_WB_ADR)
				rrc_pkg::CTRL_OFFSET:     next_state.rdata = {28'h0, state.ctrl};
				rrc_pkg::STATE_OFFSET: begin
					next_state.rdata                        = 32'h0000_0000;
					next_state.rdata[rrc_pkg::ST_REC_BIT]   = state.rec;
					next_state.rdata[rrc_pkg::ST_FEED_BIT]  = state.feed;
					next_state.rdata[rrc_pkg::ST_HALT_BIT]  = state.halt;
					next_state.rdata[rrc_pkg::ST_ERROR_BIT] = ~state.err_n;
					next_state.rdata[rrc_pkg::ST_ACQ_BIT]   = state.acq;
				end
				rrc_pkg::IRQ_STAT_OFFSET: next_state.rdata = {25'h0, state.irq_stat};
				rrc_pkg::IRQ_MASK_OFFSET: next_state.rdata = {25'h0, state.irq_mask};
				rrc_pkg::JUDGE_OFFSET:    next_state.rdata = {30'h0, state.judge};
				rrc_pkg::FAULT_OFFSET:    next_state.rdata = {30'h0, state.fault_s2};
				default:                  next_state.rdata = 32'h0000_0000;
			endcase
		end

		// ************************************************************
		// Sticky status: set wins over write-one-to-clear
		// ************************************************************
		if (wr && I_WB_ADR == rrc_pkg::IRQ_STAT_OFFSET && I_WB_SEL[0]) begin
			next_state.irq_stat = state.irq_stat & ~I_WB_DAT[rrc_pkg::IRQ_WIDTH-1:0];
		end
		next_state.irq_stat = next_state.irq_stat | events;

		// ************************************************************
		// Control and mask registers
		// ************************************************************
		if (wr && I_WB_SEL[0]) begin
			if (I_WB_ADR == rrc_pkg::CTRL_OFFSET) begin
				next_state.ctrl = I_WB_DAT[rrc_pkg::CTRL_WIDTH-1:0];
			end
			if (I_WB_ADR == rrc_pkg::IRQ_MASK_OFFSET) begin
				next_state.irq_mask = I_WB_DAT[rrc_pkg::IRQ_WIDTH-1:0];
			end
		end

		// ************************************************************
		// Judgment results from the judging engine via software
		// ************************************************************
		// A result written in the start cycle would undo the clear
		if (wr && I_WB_ADR == rrc_pkg::JUDGE_OFFSET && I_WB_SEL[1] && state.acq
		    && !fall[IN_REC]) begin
			if (I_WB_DAT[rrc_pkg::JUDGE_BLOCK_BIT] || !state.ctrl[rrc_pkg::CTRL_REPEAT_BIT]) begin
				if (I_WB_DAT[rrc_pkg::JUDGE_DONE_BIT]) begin
					next_state.judge = I_WB_DAT[rrc_pkg::JUDGE_WIDTH-1:0];
				end
			end
		end

		// ************************************************************
		// Interrupt output
		// ************************************************************
		next_state.irq = |(next_state.irq_stat & next_state.irq_mask);
	end

	// ************************************************************
	// Registers
	// ************************************************************
	always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			state <= STATE_RESET;
		end else begin
			state <= next_state;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign O_ERROR_N      = state.err_n;
	assign O_JUDGE        = state.judge;
	assign O_RECORDING    = state.rec;
	assign O_FEEDING      = state.feed;
	assign O_MARK_PRINT   = state.mark;
	assign O_LINE_ADVANCE = state.line;
	assign O_FILE_SAMPLE  = state.file_smp;
	assign O_MEM_SAMPLE   = state.mem_smp;
	assign O_HALT_REQ     = state.halt;
	assign O_WB_DAT       = state.rdata;
	assign O_WB_ACK       = state.ack;
	assign O_IRQ          = state.irq;

endmodule

//--- verification/rrc_remote_io_props.sv
/* Port checker of the remote control block.
   Bound to every rrc_remote_io instance; sees its ports only. */
`timescale 1ns/100ps
module rrc_remote_io_props (
	input wire logic       I_REF_CLK,
	input wire logic       I_RESET_N,
	input wire logic       I_REC_N,
	input wire logic       I_FEED_N,
	input wire logic       I_PROTECT_N,
	input wire logic       I_PAPER_OUT,
	input wire logic       I_HEAD_TEMP_FAULT,
	input wire logic       O_ERROR_N,
	input wire logic [1:0] O_JUDGE,
	input wire logic       O_RECORDING,
	input wire logic       O_FEEDING,
	input wire logic       O_MARK_PRINT,
	input wire logic       O_LINE_ADVANCE,
	input wire logic       O_MEM_SAMPLE,
	input wire logic       O_HALT_REQ
);
	default clocking cb @(posedge I_REF_CLK); endclocking
	default disable iff (!I_RESET_N);
	rec_hold_a: assert property ((!I_REC_N)[*8] |-> O_RECORDING) else $error("recording not held");
	rec_stop_a: assert property (I_REC_N[*8] |-> !O_RECORDING) else $error("recording not stopped");
	feed_hold_a: assert property ((!I_FEED_N)[*8] |-> O_FEEDING) else $error("feed not held");
	feed_stop_a: assert property (I_FEED_N[*8] |-> !O_FEEDING) else $error("feed not stopped");
	mark_strobe_a: assert property ($rose(O_MARK_PRINT) |-> O_RECORDING ##1 O_MARK_PRINT[*8] ##1 O_MARK_PRINT
		##1 !O_MARK_PRINT) else $error("mark strobe wrong");
	err_set_a: assert property ((I_PAPER_OUT || I_HEAD_TEMP_FAULT)[*5] |-> !O_ERROR_N)
		else $error("error output not low");
	err_clear_a: assert property ((!I_PAPER_OUT && !I_HEAD_TEMP_FAULT)[*5] |-> O_ERROR_N)
		else $error("error output not high");
	line_pulse_a: assert property (O_LINE_ADVANCE |-> O_RECORDING ##1 !O_LINE_ADVANCE)
		else $error("line pulse wrong");
	mem_pulse_a: assert property (O_MEM_SAMPLE |-> O_RECORDING ##1 !O_MEM_SAMPLE) else $error("sample pulse wrong");
	halt_start_a: assert property ($fell(I_PROTECT_N) ##0 (!I_PROTECT_N)[*3] |-> ##[1:3] O_HALT_REQ)
		else $error("halt not requested");
	judge_clear_a: assert property ($rose(O_RECORDING) |-> ##[0:1] (O_JUDGE == 2'h0))
		else $error("judgment not cleared");
endmodule

bind rrc_remote_io rrc_remote_io_props chk_u (
	.I_REF_CLK(I_REF_CLK), .I_RESET_N(I_RESET_N), .I_REC_N(I_REC_N), .I_FEED_N(I_FEED_N),
	.I_PROTECT_N(I_PROTECT_N), .I_PAPER_OUT(I_PAPER_OUT), .I_HEAD_TEMP_FAULT(I_HEAD_TEMP_FAULT),
	.O_ERROR_N(O_ERROR_N), .O_JUDGE(O_JUDGE), .O_RECORDING(O_RECORDING), .O_FEEDING(O_FEEDING),
	.O_MARK_PRINT(O_MARK_PRINT), .O_LINE_ADVANCE(O_LINE_ADVANCE), .O_MEM_SAMPLE(O_MEM_SAMPLE),
	.O_HALT_REQ(O_HALT_REQ)
);

//--- verification/rrc_remote_ctl.sv
/* Model of the remote controller wired to the remote pins.
   Changes its pins just after a rising edge of the system clock. */
`timescale 1ns/100ps
module rrc_remote_ctl (
	// Clock
	input  wire logic i_clk,
	// Remote pins
	output logic      o_rec_n,
	output logic      o_feed_n,
	output logic      o_mark_n,
	output logic      o_protect_n,
	output logic      o_print_sync,
	output logic      o_ext_pulse
);
	logic [3:0] lvl = 4'hf;
	logic       pulse = 1'b0;
	logic       both = 1'b0;
	assign o_rec_n = lvl[0];
	assign o_feed_n = lvl[1];
	assign o_mark_n = lvl[2];
	assign o_protect_n = lvl[3];
	assign o_print_sync = pulse & both;
	assign o_ext_pulse = pulse;

	// Level on rec, feed, mark or protect pin
	task automatic put(input int b, input logic v);
		@(posedge i_clk);
		lvl[b] <= v;
	endtask

	// Pulses two cycles high and two low, optionally on both pacing pins
	task automatic pulses(input int n, input logic sync_too);
		repeat (n) begin
			@(posedge i_clk);
			pulse <= 1'b1;
			both <= sync_too;
			repeat (2) @(posedge i_clk);
			pulse <= 1'b0;
			@(posedge i_clk);
		end
	endtask
endmodule

//--- verification/rrc_remote_io_test.sv
/* Self-checking bench of the remote control block.
   Needs rrc_pkg, the design, the controller model and the checker. */
`timescale 1ns/100ps
module rrc_remote_io_test;
	localparam logic [31:0] MEM = 32'h1 << rrc_pkg::CTRL_MODE_BIT;
	localparam logic [31:0] EXT = 32'h1 << rrc_pkg::CTRL_EXT_BIT;
	localparam logic [31:0] FINE = 32'h1 << rrc_pkg::CTRL_SCALE_BIT;
	localparam logic [31:0] REP = 32'h1 << rrc_pkg::CTRL_REPEAT_BIT;
	localparam logic [31:0] DONE = 32'h1 << rrc_pkg::JUDGE_DONE_BIT;
	localparam logic [31:0] BLK = 32'h1 << rrc_pkg::JUDGE_BLOCK_BIT;
	logic        clk = 1'b0, rst_n = 1'b0, paper = 1'b0, head = 1'b0;
	logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, mark_q = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] wdat = 32'h0, rdat, rd;
	logic        rec_n, feed_n, mark_n, prot_n, psync, epulse;
	logic        err_n, rec, feed, mark, line, file, mem, halt, ack, irq;
	logic [1:0]  judge, j, j2;
	int          errors = 0, comparisons = 0, marks = 0, lines = 0, files = 0, mems = 0, n, f, seed;

	rrc_remote_ctl ctl_u (.i_clk(clk), .o_rec_n(rec_n), .o_feed_n(feed_n), .o_mark_n(mark_n),
		.o_protect_n(prot_n), .o_print_sync(psync), .o_ext_pulse(epulse));
	rrc_remote_io dut_u (.I_REF_CLK(clk), .I_RESET_N(rst_n), .I_REC_N(rec_n), .I_FEED_N(feed_n),
		.I_MARK_N(mark_n), .I_PROTECT_N(prot_n), .I_PRINT_SYNC(psync), .I_EXTERNAL_PULSE_IN(epulse),
		.I_PAPER_OUT(paper), .I_HEAD_TEMP_FAULT(head), .O_ERROR_N(err_n), .O_JUDGE(judge),
		.O_RECORDING(rec), .O_FEEDING(feed), .O_MARK_PRINT(mark), .O_LINE_ADVANCE(line),
		.O_FILE_SAMPLE(file), .O_MEM_SAMPLE(mem), .O_HALT_REQ(halt), .I_WB_CYC(cyc), .I_WB_STB(stb),
		.I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(4'hf), .I_WB_DAT(wdat), .O_WB_DAT(rdat),
		.O_WB_ACK(ack), .O_IRQ(irq));

	initial begin
		forever #50 clk = ~clk;
	end

	always @(posedge clk) begin
		marks += int'(mark & ~mark_q);
		mark_q = mark;
		lines += int'(line);
		files += int'(file);
		mems += int'(mem);
	end

	function automatic int per_line(input int p, input logic fine);
		return fine ? p / 4 : p;
	endfunction

	task automatic print_verdict();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		for (k = 0; k < 20; k++) begin
			@(posedge clk);
			if (ack === 1'b1)
				break;
		end
		if (ack !== 1'b1) begin
			errors++;
			print_verdict();
		end else begin
			rd = rdat;
			cyc <= 1'b0;
			stb <= 1'b0;
		end
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		print_verdict();
	end

	initial begin
		seed = $urandom(32'h31864eda);
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		wb(1'b0, rrc_pkg::CTRL_OFFSET, 32'h0);
		chk("ctrl reset", 32'(rrc_pkg::CTRL_RESET), rd);
		wb(1'b0, rrc_pkg::IRQ_STAT_OFFSET, 32'h0);
		chk("irq status reset", 32'(rrc_pkg::IRQ_RESET), rd);
		wb(1'b1, 8'h1c, 32'hffffffff);
		wb(1'b0, 8'h1c, 32'h0);
		chk("unmapped read", 32'h0, rd);
		for (int i = 0; i < 6; i++) begin
			f = $urandom % 4;
			paper <= f[0];
			head <= f[1];
			repeat (6) @(posedge clk);
			chk("error output", {31'h0, ~(f[0] | f[1])}, err_n);
		end
		paper <= 1'b0;
		head <= 1'b0;
		ctl_u.put(1, 1'b0);
		repeat (6) @(posedge clk);
		chk("feeding", 1, feed);
		ctl_u.put(1, 1'b1);
		repeat (6) @(posedge clk);
		chk("feed stopped", 0, feed);
		wb(1'b1, rrc_pkg::IRQ_MASK_OFFSET, 32'h1 << rrc_pkg::IRQ_REC_START);
		ctl_u.put(0, 1'b0);
		repeat (6) @(posedge clk);
		chk("recording", 1, rec);
		chk("judge at start", 0, judge);
		chk("irq raised", 1, irq);
		wb(1'b1, rrc_pkg::IRQ_STAT_OFFSET, 32'h1 << rrc_pkg::IRQ_REC_START);
		repeat (2) @(posedge clk);
		chk("irq cleared", 0, irq);
		j = 2'(1 + $urandom % 2);
		wb(1'b1, rrc_pkg::JUDGE_OFFSET, DONE | 32'(j));
		repeat (2) @(posedge clk);
		chk("judge result", 32'(j), judge);
		marks = 0;
		ctl_u.put(2, 1'b0);
		repeat (3) @(posedge clk);
		ctl_u.put(2, 1'b1);
		repeat (16) @(posedge clk);
		chk("marks real-time", 1, marks);
		for (int s = 0; s < 2; s++) begin
			wb(1'b1, rrc_pkg::CTRL_OFFSET, s ? EXT | FINE : EXT);
			lines = 0;
			files = 0;
			n = 4 * (1 + $urandom % 4);
			ctl_u.pulses(n, 1'b1);
			repeat (6) @(posedge clk);
			chk("lines", per_line(n, s[0]), lines);
			chk("filing samples", per_line(n, s[0]), files);
		end
		wb(1'b1, rrc_pkg::CTRL_OFFSET, MEM | EXT | FINE);
		mems = 0;
		marks = 0;
		n = 1 + $urandom % 6;
		ctl_u.pulses(n, 1'b0);
		ctl_u.put(2, 1'b0);
		repeat (3) @(posedge clk);
		ctl_u.put(2, 1'b1);
		repeat (16) @(posedge clk);
		chk("memory samples", n, mems);
		chk("marks memory", 0, marks);
		wb(1'b1, rrc_pkg::CTRL_OFFSET, MEM | REP);
		j2 = j + 2'h1;
		wb(1'b1, rrc_pkg::JUDGE_OFFSET, DONE | 32'(j2));
		repeat (2) @(posedge clk);
		chk("judge held", 32'(j), judge);
		wb(1'b1, rrc_pkg::JUDGE_OFFSET, DONE | BLK | 32'(j2));
		repeat (2) @(posedge clk);
		chk("judge new block", 32'(j2), judge);
		ctl_u.put(0, 1'b1);
		repeat (6) @(posedge clk);
		chk("recording stopped", 0, rec);
		ctl_u.put(0, 1'b0);
		repeat (6) @(posedge clk);
		chk("judge restart", 0, judge);
		ctl_u.put(3, 1'b0);
		repeat (6) @(posedge clk);
		chk("halt request", 1, halt);
		wb(1'b0, rrc_pkg::STATE_OFFSET, 32'h0);
		chk("state register", (32'h1 << rrc_pkg::ST_REC_BIT) | (32'h1 << rrc_pkg::ST_HALT_BIT)
			| (32'h1 << rrc_pkg::ST_ACQ_BIT), rd);
		print_verdict();
	end
endmodule
